// file: rtl/pil_pkg.sv
// Package with register map, field positions and reset values of the interrupt status latch
package pil_pkg;
  localparam logic [4:0]  STATUS_ADDR      = 5'h19;
  localparam logic [4:0]  MASK_ADDR        = 5'h18;
  localparam logic [15:0] STATUS_RESET     = 16'h0000;
  localparam logic [15:0] MASK_RESET       = 16'h0000;
  localparam int          EVENT_COUNT      = 10;
  localparam int          PENDING_BIT      = 0;
  localparam int          SPEED_BIT        = 1;
  localparam int          LINK_BIT         = 2;
  localparam int          RECEIVE_BIT      = 3;
  localparam int          MAC_FIFO_BIT     = 4;
  localparam int          IDLE_ERR_BIT     = 5;
  localparam int          PAGE_RX_BIT      = 6;
  localparam int          FRAME_TEST_BIT   = 7;
  localparam int          NEGOTIATION_BIT  = 8;
  localparam int          SYNC_LOST_BIT    = 9;
  localparam int          CABLE_TEST_BIT   = 10;
  localparam int          PIN_ENABLE_BIT   = 0;
  localparam logic [15:0] SOURCE_FIELD     = 16'h07FE;
endpackage : pil_pkg

// file: rtl/pil_flag_cell.sv
// Single sticky flag with set-over-clear priority
`timescale 1ns/1ns
`default_nettype none
module pil_flag_cell
(
  input  wire logic i_clk_sys,
  input  wire logic i_rst_n,
  input  wire logic i_set,
  input  wire logic i_clear,
  output var  logic o_flag
);
  typedef struct packed
  {
    logic flag_reg;
  } pil_cell_type;

  pil_cell_type state_reg;
  pil_cell_type state_next;

  always_comb
  begin
    state_next = state_reg;
    if (i_clear)
    begin
      state_next.flag_reg = 1'b0;
    end
    // Set wins so an event during the clearing read survives
    if (i_set)
    begin
      state_next.flag_reg = 1'b1; // R2 R13
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign o_flag = state_reg.flag_reg;
endmodule : pil_flag_cell
`default_nettype wire

// file: rtl/pil_status_latch.sv
// Interrupt status latch: sticky event flags, mask register, pending summary and pin
// ==========================================================================
// Notes on behaviour
// R1: Status register at address 0x19, all bits zero after reset.
// R2: A firing source sets its flag, held until the register is read.
// R3: Any read of the status register clears every latched flag at once.
// R4: Source flags set regardless of their mask enable.
// R5: Pending summary derives only from enabled source events.
// R6: Bit 10 cable test, bit 9 sync lost, bit 8 negotiation change.
// R7: Bit 7 frame tester, bit 6 page received, bit 5 idle error saturated.
// R8: Bit 4 MAC FIFO overrun/underrun, bit 3 receive change, bit 2 link change.
// R9: Bit 1 speed change, latched like the other flags.
// R10: Bit 0 pending, set on enabled interrupt, latched until read.
// R11: Mask register at 0x18, per-source enables reset to zero.
// R12: Active-low pin asserted on interrupt only while mask bit 0 set.
// R13: Event in the same cycle as a clearing read stays set.
`timescale 1ns/1ns
`default_nettype none
module pil_status_latch
(
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_n,
  input  wire logic        i_cable_test_event,
  input  wire logic        i_sync_lost_event,
  input  wire logic        i_negotiation_state_change_event,
  input  wire logic        i_frame_tester_event,
  input  wire logic        i_page_received_event,
  input  wire logic        i_idle_error_saturated_event,
  input  wire logic        i_mac_fifo_overrun_underrun_event,
  input  wire logic        i_receive_state_change_event,
  input  wire logic        i_link_state_change_event,
  input  wire logic        i_speed_change_event,
  input  wire logic [4:0]  i_reg_addr,
  input  wire logic        i_reg_read,
  input  wire logic        i_reg_write,
  input  wire logic [15:0] i_reg_wdata,
  output var  logic [15:0] o_reg_rdata,
  output var  logic        o_irq_n
);
  // ==========================================================================
  // State
  typedef struct packed
  {
    logic [15:0] mask_reg;
    logic [15:0] rdata_reg;
    logic        irq_n_reg;
  } pil_state_type;

  pil_state_type state_reg;
  pil_state_type state_next;

  logic [15:0] event_vec;
  logic [15:0] flags;
  logic        status_read;
  logic        pending_set;

  function automatic logic addr_hit(input logic [4:0] addr, input logic [4:0] target);
    addr_hit = (addr == target);
  endfunction : addr_hit

  // ==========================================================================
  // Event bit placement
  always_comb
  begin
    event_vec = 16'h0000;
    event_vec[pil_pkg::CABLE_TEST_BIT]  = i_cable_test_event; // R6
    event_vec[pil_pkg::SYNC_LOST_BIT]   = i_sync_lost_event; // R6
    event_vec[pil_pkg::NEGOTIATION_BIT] = i_negotiation_state_change_event; // R6
    event_vec[pil_pkg::FRAME_TEST_BIT]  = i_frame_tester_event; // R7
    event_vec[pil_pkg::PAGE_RX_BIT]     = i_page_received_event; // R7
    event_vec[pil_pkg::IDLE_ERR_BIT]    = i_idle_error_saturated_event; // R7
    event_vec[pil_pkg::MAC_FIFO_BIT]    = i_mac_fifo_overrun_underrun_event; // R8
    event_vec[pil_pkg::RECEIVE_BIT]     = i_receive_state_change_event; // R8
    event_vec[pil_pkg::LINK_BIT]        = i_link_state_change_event; // R8
    event_vec[pil_pkg::SPEED_BIT]       = i_speed_change_event; // R9
  end

  assign status_read = i_reg_read && addr_hit(i_reg_addr, pil_pkg::STATUS_ADDR); // R1
  // Enabled events only; mask is ignored for the sticky flags themselves
  assign pending_set = |(event_vec & state_reg.mask_reg & pil_pkg::SOURCE_FIELD); // R5

  // ==========================================================================
  // Sticky flags
  genvar g;
  generate
    for (g = 0; g <= pil_pkg::EVENT_COUNT; g++)
    begin : g_flag
      if (g == pil_pkg::PENDING_BIT)
      begin : g_pend
        pil_flag_cell u_cell
        (
          .i_clk_sys (i_clk_sys),
          .i_rst_n   (i_rst_n),
          .i_set     (pending_set), // R10
          .i_clear   (status_read), // R3
          .o_flag    (flags[g])
        );
      end
      else
      begin : g_src
        pil_flag_cell u_cell
        (
          .i_clk_sys (i_clk_sys),
          .i_rst_n   (i_rst_n),
          .i_set     (event_vec[g]), // R2 R4
          .i_clear   (status_read), // R3
          .o_flag    (flags[g])
        );
      end
    end
  endgenerate
  // Reserved bits read zero
  assign flags[15:pil_pkg::EVENT_COUNT+1] = '0;

  // ==========================================================================
  // Register access and pin
  always_comb
  begin
    state_next = state_reg;
    if (i_reg_write && addr_hit(i_reg_addr, pil_pkg::MASK_ADDR))
    begin
      state_next.mask_reg = i_reg_wdata; // R11
    end
    if (i_reg_read)
    begin
      if (addr_hit(i_reg_addr, pil_pkg::STATUS_ADDR))
      begin
        state_next.rdata_reg = flags; // R1
      end
      else if (addr_hit(i_reg_addr, pil_pkg::MASK_ADDR))
      begin
        state_next.rdata_reg = state_reg.mask_reg;
      end
      else
      begin
        state_next.rdata_reg = 16'h0000;
      end
    end
    // Pin follows pending one cycle later; a read drops it with the flag
    state_next.irq_n_reg = !(flags[pil_pkg::PENDING_BIT] && !status_read
                             && state_reg.mask_reg[pil_pkg::PIN_ENABLE_BIT]); // R12
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_reg.mask_reg  <= pil_pkg::MASK_RESET; // R11
      state_reg.rdata_reg <= pil_pkg::STATUS_RESET;
      state_reg.irq_n_reg <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign o_reg_rdata = state_reg.rdata_reg;
  assign o_irq_n     = state_reg.irq_n_reg;

  // ==========================================================================
  // Checks
  sequence read_seq;
    status_read;
  endsequence

  sequence cleared_seq;
    flags == 16'h0000;
  endsequence

  read_clears_a : assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // R3
    read_seq and (event_vec == 16'h0000) |=> cleared_seq)
    else $error("Status read did not clear all flags");

  event_latch_a : assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // R2
    i_link_state_change_event |=> flags[pil_pkg::LINK_BIT])
    else $error("Link event not latched");

  set_wins_a : assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // R13
    status_read && i_speed_change_event |=> flags[pil_pkg::SPEED_BIT])
    else $error("Event lost during clearing read");

  unmasked_set_a : assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // R4
    i_cable_test_event && !state_reg.mask_reg[pil_pkg::CABLE_TEST_BIT]
    |=> flags[pil_pkg::CABLE_TEST_BIT])
    else $error("Masked source flag not set");

  masked_pend_a : assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // R5
    !flags[pil_pkg::PENDING_BIT] && !pending_set |=> !flags[pil_pkg::PENDING_BIT])
    else $error("Pending set without enabled source");

  pending_hold_a : assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // R10
    flags[pil_pkg::PENDING_BIT] && !status_read |=> flags[pil_pkg::PENDING_BIT])
    else $error("Pending dropped without read");

  status_rdata_a : assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // R1
    read_seq |=> (o_reg_rdata == $past(flags)))
    else $error("Status read data wrong");

  pin_gate_a : assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // R12
    !state_reg.mask_reg[pil_pkg::PIN_ENABLE_BIT] |=> o_irq_n)
    else $error("Pin asserted while disabled");

  mask_write_a : assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // R11
    i_reg_write && i_reg_addr == pil_pkg::MASK_ADDR |=> state_reg.mask_reg == $past(i_reg_wdata))
    else $error("Mask write not stored");

  // Pending latched, not being read, pin enabled
  sequence pin_armed_seq;
    flags[pil_pkg::PENDING_BIT] && !status_read && state_reg.mask_reg[pil_pkg::PIN_ENABLE_BIT];
  endsequence

  pin_drive_a : assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // R12
    pin_armed_seq |=> !o_irq_n)
    else $error("Pin not asserted for pending interrupt");

  pending_set_a : assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // R10
    pending_set |=> flags[pil_pkg::PENDING_BIT])
    else $error("Enabled event did not set pending");

  read_release_a : assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // R3
    read_seq |=> o_irq_n)
    else $error("Pin still asserted after clearing read");
endmodule : pil_status_latch
`default_nettype wire

// file: testbench/pil_mgmt_model.sv
// Station management model issuing register reads and writes
`timescale 1ns/1ns
`default_nettype none
module pil_mgmt_model
(
  input  wire logic        i_clk_sys,
  input  wire logic [15:0] i_reg_rdata,
  output var  logic [4:0]  o_reg_addr,
  output var  logic        o_reg_read,
  output var  logic        o_reg_write,
  output var  logic [15:0] o_reg_wdata
);
  initial
  begin
    o_reg_addr  = 5'h00;
    o_reg_read  = 1'b0;
    o_reg_write = 1'b0;
    o_reg_wdata = 16'h0000;
  end
  // ==========================================================
  // Access tasks, entered and left at a falling edge
  // Released address and data are inverted so stale values never help
  task automatic rd(input logic [4:0] a, output logic [15:0] q);
    o_reg_addr = a;
    o_reg_read = 1'b1;
    @(negedge i_clk_sys);
    o_reg_read = 1'b0;
    o_reg_addr = ~a;
    @(negedge i_clk_sys);
    q = i_reg_rdata;
  endtask : rd
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    o_reg_addr  = a;
    o_reg_wdata = d;
    o_reg_write = 1'b1;
    @(negedge i_clk_sys);
    o_reg_write = 1'b0;
    o_reg_addr  = ~a;
    o_reg_wdata = ~d;
    // Let an edge pass so the next task never re-drives the address in this step
    @(negedge i_clk_sys);
  endtask : wr
endmodule : pil_mgmt_model
`default_nettype wire

// file: testbench/pil_status_latch_tb.sv
// Testbench for the interrupt status latch
`timescale 1ns/1ns
`default_nettype none
module pil_status_latch_tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [10:1] ev = 10'h000;
  logic [4:0]  addr;
  logic        rd_s;
  logic        wr_s;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        irq_n;
  int          error_cnt = 0;
  int          check_count = 0;
  localparam logic [4:0] ST = pil_pkg::STATUS_ADDR;
  localparam logic [4:0] MK = pil_pkg::MASK_ADDR;
  always #10 clk = ~clk;
  pil_status_latch i_pil_status_latch (.i_clk_sys(clk), .i_rst_n(rst_n),
    .i_cable_test_event(ev[10]), .i_sync_lost_event(ev[9]),
    .i_negotiation_state_change_event(ev[8]), .i_frame_tester_event(ev[7]),
    .i_page_received_event(ev[6]), .i_idle_error_saturated_event(ev[5]),
    .i_mac_fifo_overrun_underrun_event(ev[4]), .i_receive_state_change_event(ev[3]),
    .i_link_state_change_event(ev[2]), .i_speed_change_event(ev[1]),
    .i_reg_addr(addr), .i_reg_read(rd_s), .i_reg_write(wr_s),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_irq_n(irq_n));
  pil_mgmt_model i_pil_mgmt_model (.i_clk_sys(clk), .i_reg_rdata(rdata),
    .o_reg_addr(addr), .o_reg_read(rd_s), .o_reg_write(wr_s), .o_reg_wdata(wdata));
  // ==========================================================
  // Helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR %0t: read %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rchk(input logic [4:0] a, input logic [15:0] exp);
    logic [15:0] q;
    i_pil_mgmt_model.rd(a, q);
    chk(q, exp);
  endtask : rchk
  task automatic pulse(input logic [10:1] e);
    ev = e;
    @(negedge clk);
    ev = 10'h000;
  endtask : pulse
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  // ==========================================================
  // Tests
  initial
  begin
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    rchk(ST, 16'h0000);
    rchk(MK, 16'h0000);
    chk({15'h0000, irq_n}, 16'h0001);
    $display("test reset done");
    for (int k = 1; k <= 10; k++)
    begin
      pulse(10'h001 << (k - 1));
      rchk(ST, 16'h0001 << k);
    end
    pulse(10'h3FF);
    rchk(ST, 16'h07FE);
    rchk(ST, 16'h0000);
    $display("test flags done");
    i_pil_mgmt_model.wr(MK, 16'hF805);
    rchk(MK, 16'hF805);
    pulse(10'h001);
    @(negedge clk);
    chk({15'h0000, irq_n}, 16'h0001);
    rchk(ST, 16'h0002);
    pulse(10'h002);
    @(negedge clk);
    chk({15'h0000, irq_n}, 16'h0000);
    rchk(ST, 16'h0005);
    chk({15'h0000, irq_n}, 16'h0001);
    i_pil_mgmt_model.wr(MK, 16'h0004);
    pulse(10'h002);
    @(negedge clk);
    chk({15'h0000, irq_n}, 16'h0001);
    rchk(ST, 16'h0005);
    $display("test mask done");
    fork
      rchk(ST, 16'h0000);
      pulse(10'h002);
    join
    rchk(ST, 16'h0005);
    i_pil_mgmt_model.wr(ST, 16'hFFFF);
    rchk(ST, 16'h0000);
    rchk(5'h03, 16'h0000);
    $display("test edge cases done");
    i_pil_mgmt_model.wr(MK, 16'h0005);
    pulse(10'h002);
    rst_n = 1'b0;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    chk({15'h0000, irq_n}, 16'h0001);
    rchk(MK, 16'h0000);
    rchk(ST, 16'h0000);
    $display("test reset again done");
    stop_test();
  end
  initial
  begin
    #100000;
    error_cnt++;
    stop_test();
  end
endmodule : pil_status_latch_tb
`default_nettype wire
